//--- shared/ppg_pkg.sv
package ppg_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned VAL_W  = 10;

  localparam logic [11:0] CTRL_TWO_ADDR   = 12'he99;
  localparam logic [11:0] CTRL_THREE_ADDR = 12'he9a;
  localparam logic [11:0] DEAD_ONE_LO     = 12'he9b;
  localparam logic [11:0] DEAD_ONE_HI     = 12'he9c;
  localparam logic [11:0] WIDTH_ONE_LO    = 12'he9d;
  localparam logic [11:0] WIDTH_ONE_HI    = 12'he9e;

  // Control two fields
  localparam int unsigned C2_RELEASE = 7;
  localparam int unsigned C2_EMG_EN  = 6;
  localparam int unsigned C2_GATE2   = 5;
  localparam int unsigned C2_GATE1   = 4;
  localparam int unsigned C2_CSM_HI  = 3;
  localparam int unsigned C2_CSM_LO  = 2;
  localparam int unsigned C2_WFM_HI  = 1;
  localparam int unsigned C2_WFM_LO  = 0;

  // Control three fields
  localparam int unsigned C3_EMG_FLAG = 5;
  localparam int unsigned C3_COUNTING = 4;
  localparam int unsigned C3_SUPPRESS = 3;
  localparam int unsigned C3_STM_HI   = 2;
  localparam int unsigned C3_STM_LO   = 1;
  localparam int unsigned C3_RUN      = 0;

  localparam logic [7:0] REG_RESET  = 8'h00;
  localparam logic [1:0] FIELD_ZERO = 2'h0;
  localparam logic [9:0] VAL_ZERO   = 10'h000;
  localparam logic [9:0] VAL_ONE    = 10'h001;

  localparam logic [1:0] CSM_CMD_CAPTURE = 2'h0;
  localparam logic [1:0] CSM_CMD_TRIG    = 2'h1;
  localparam logic [1:0] CSM_TRIG_ONLY   = 2'h2;

  localparam logic [1:0] WFM_INDEP    = 2'h0;
  localparam logic [1:0] WFM_VARIABLE = 2'h2;
  localparam logic [1:0] WFM_HALF     = 2'h3;

  localparam logic [1:0] STM_ONE_SHOT = 2'h2;

  // Noise filter widths in gear clock periods
  localparam logic [1:0] NF_NONE      = 2'h3;
  localparam logic [4:0] NF_CYCLES_16 = 5'h10;
  localparam logic [4:0] NF_CYCLES_8  = 5'h08;
  localparam logic [4:0] NF_CYCLES_4  = 5'h04;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_ARMED  = 4'b0010,
    ST_RUN    = 4'b0100,
    ST_FINISH = 4'b1000
  } run_state_e;
endpackage

//--- hw/ppg_noise_filter.sv
`timescale 1ns/1ps
module ppg_noise_filter
  import ppg_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       ce_i,
  input  wire logic       pin_i,
  input  wire logic [1:0] sel_i,
  output logic            level_o
);
  typedef struct packed {
    logic       sync1;
    logic       sync2;
    logic       level;
    logic [4:0] run;
  } filt_s;

  filt_s state_reg;
  filt_s state_next;
  logic [4:0] need;

  always_comb begin
    state_next       = state_reg;
    state_next.sync1 = pin_i;
    state_next.sync2 = state_reg.sync1;
    unique case (sel_i)
      2'h0:    need = NF_CYCLES_16;
      2'h1:    need = NF_CYCLES_8;
      2'h2:    need = NF_CYCLES_4;
      default: need = 5'h00;
    endcase
    // Level must stay changed for the full width before it is passed on
    if (state_reg.sync2 == state_reg.level) begin
      state_next.run = 5'h00;
    end else if (sel_i == NF_NONE || (state_reg.run + 5'h01) >= need) begin // RULE_21
      state_next.level = state_reg.sync2;
      state_next.run   = 5'h00;
    end else begin
      state_next.run = state_reg.run + 5'h01;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= '0;
    end else if (ce_i) begin
      state_reg <= state_next;
    end
  end

  assign level_o = state_reg.level;
endmodule

//--- hw/ppg_setup_reg.sv
`timescale 1ns/1ps
module ppg_setup_reg
  import ppg_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       ce_i,
  input  wire logic       wr_lo_i,
  input  wire logic       wr_hi_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       commit_i,
  output logic      [9:0] hold_o,
  output logic      [9:0] cmp_o
);
  typedef struct packed {
    logic [9:0] hold;
    logic [9:0] cmp;
  } setup_s;

  setup_s state_reg;
  setup_s state_next;

  always_comb begin
    state_next = state_reg;
    if (wr_lo_i) begin
      state_next.hold[7:0] = wdata_i;
    end
    if (wr_hi_i) begin
      state_next.hold[9:8] = wdata_i[1:0]; // RULE_18
    end
    // Compare copy only moves when the period high byte is written
    if (commit_i) begin
      state_next.cmp = state_reg.hold; // RULE_19 RULE_16
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= '0;
    end else if (ce_i) begin
      state_reg <= state_next;
    end
  end

  assign hold_o = state_reg.hold;
  assign cmp_o  = state_reg.cmp;
endmodule

//--- hw/ppg_timer_run_control.sv
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01 - Release bit write 1 cancels emergency
// RULE_02 - Release bit always reads zero
// RULE_03 - Enable bit gates the emergency pin
// RULE_04 - Gate mode blocks triggers during active output
// RULE_05 - Start mode: capture, command+trigger, trigger
// RULE_06 - Waveform: independent, variable duty, half duty
// RULE_07 - Emergency flag reads one while stopped
// RULE_08 - Counting flag reads one while counting
// RULE_09 - Suppress bit hides first period interrupt (code hides it only after a command start, not after a trigger start)
// RULE_10 - Stop codes 0x stop and clear immediately
// RULE_11 - Stop code 10 finishes current period
// RULE_12 - Run with code 10 gives one shot
// RULE_13 - Hardware never changes the run bit
// RULE_14 - Software stops before rewriting control one/two
// RULE_15 - Control three write while running restarts
// RULE_16 - Compares load on period high byte write
// RULE_17 - Control three bits 7,6 read zero
// RULE_18 - Setup value ten bits, upper bits zero
// RULE_19 - Setup registers are double buffered
// RULE_20 - Software writes low byte before high
// RULE_21 - Trigger filter rejects 16, 8, 4 cycles
// RULE_22 - Emergency forces outputs to stop levels
// RULE_23 - Reserved codes stored as written
module ppg_timer_run_control
  import ppg_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        ce_i,
  input  wire logic [11:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  input  wire logic        trig_gate_mode_i,
  input  wire logic        trig_rising_i,
  input  wire logic        out1_init_i,
  input  wire logic        out2_init_i,
  input  wire logic [1:0]  noise_filter_sel_i,
  input  wire logic [9:0]  period_cmp_i,
  input  wire logic        period_commit_i,
  input  wire logic        trigger_pin_i,
  input  wire logic        emergency_input_pin_i,
  output logic             pulse_output_one_o,
  output logic             pulse_output_two_o,
  output logic             period_interrupt_o,
  output logic             counting_o
);
  typedef struct packed {
    run_state_e  st;
    logic        emergency_input_enable;
    logic        out2_trigger_gate;
    logic        out1_trigger_gate;
    logic [1:0]  count_start_mode_sel;
    logic [1:0]  waveform_mode_sel;
    logic        first_irq_suppress;
    logic [1:0]  stop_behaviour_sel;
    logic        run_bit;
    logic        emergency_stop_flag;
    logic        emg_sync1;
    logic        emg_sync2;
    logic        trig_prev;
    logic [9:0]  cnt;
    logic        first_period;
    logic        half_phase;
    logic        out1;
    logic        out2;
    logic        irq;
    logic [7:0]  rdata;
  } ctrl_s;

  ctrl_s state_reg;
  ctrl_s state_next;

  logic       trig_level;
  logic [9:0] dead_hold;
  logic [9:0] dead_cmp;
  logic [9:0] width_hold;
  logic [9:0] width_cmp;
  logic       wr_c2;
  logic       wr_c3;
  logic       cmd_mode;
  logic       trig_start_mode;
  logic       counting;
  logic       act1;
  logic       act2;
  logic       trig_edge;
  logic       trig_ok;
  logic       period_end;
  logic [9:0] dead_end;

  ppg_noise_filter u_filter (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .ce_i    (ce_i),
    .pin_i   (trigger_pin_i),
    .sel_i   (noise_filter_sel_i),
    .level_o (trig_level)
  );

  ppg_setup_reg u_dead_one (
    .clk_i    (clk_i),
    .rstn_i   (rstn_i),
    .ce_i     (ce_i),
    .wr_lo_i  (wr_i && addr_i == DEAD_ONE_LO),
    .wr_hi_i  (wr_i && addr_i == DEAD_ONE_HI),
    .wdata_i  (wdata_i),
    .commit_i (period_commit_i),
    .hold_o   (dead_hold),
    .cmp_o    (dead_cmp)
  );

  ppg_setup_reg u_width_one (
    .clk_i    (clk_i),
    .rstn_i   (rstn_i),
    .ce_i     (ce_i),
    .wr_lo_i  (wr_i && addr_i == WIDTH_ONE_LO),
    .wr_hi_i  (wr_i && addr_i == WIDTH_ONE_HI),
    .wdata_i  (wdata_i),
    .commit_i (period_commit_i),
    .hold_o   (width_hold),
    .cmp_o    (width_cmp)
  );

  assign wr_c2    = wr_i && addr_i == CTRL_TWO_ADDR;
  assign wr_c3    = wr_i && addr_i == CTRL_THREE_ADDR;
  assign counting = state_reg.st == ST_RUN || state_reg.st == ST_FINISH;
  assign dead_end = 10'(dead_cmp + width_cmp);

  always_comb begin
    // Reserved start code waits for a trigger like trigger mode, but a trigger never restarts it
    cmd_mode = state_reg.count_start_mode_sel == CSM_CMD_CAPTURE
            || state_reg.count_start_mode_sel == CSM_CMD_TRIG; // RULE_05
    trig_start_mode = state_reg.count_start_mode_sel == CSM_CMD_TRIG
                   || state_reg.count_start_mode_sel == CSM_TRIG_ONLY; // RULE_05
    // Raw active levels before the initial-level polarity
    unique case (state_reg.waveform_mode_sel)
      WFM_VARIABLE: begin
        act1 = state_reg.cnt < width_cmp; // RULE_06
        act2 = !act1;
      end
      WFM_HALF: begin
        act1 = state_reg.half_phase; // RULE_06
        act2 = !state_reg.half_phase;
      end
      default: begin
        // Independent, also used for the reserved code
        act1 = state_reg.cnt >= dead_cmp && state_reg.cnt < dead_end; // RULE_06
        act2 = state_reg.cnt >= dead_end;
      end
    endcase
    act1 = act1 && counting;
    act2 = act2 && counting;
    trig_edge = trig_rising_i ? (trig_level && !state_reg.trig_prev)
                              : (!trig_level && state_reg.trig_prev);
    trig_ok = trig_edge && !(trig_gate_mode_i
              && ((state_reg.out1_trigger_gate && act1)
               || (state_reg.out2_trigger_gate && act2))); // RULE_04
    period_end = state_reg.cnt >= period_cmp_i;
  end

  always_comb begin
    state_next           = state_reg;
    state_next.emg_sync1 = emergency_input_pin_i;
    state_next.emg_sync2 = state_reg.emg_sync1;
    state_next.trig_prev = trig_level;
    state_next.irq       = 1'b0;
    state_next.rdata     = REG_RESET;

    if (wr_c2) begin
      // Release bit is an action, never stored
      state_next.emergency_input_enable = wdata_i[C2_EMG_EN];
      state_next.out2_trigger_gate      = wdata_i[C2_GATE2];
      state_next.out1_trigger_gate      = wdata_i[C2_GATE1];
      state_next.count_start_mode_sel   = wdata_i[C2_CSM_HI:C2_CSM_LO]; // RULE_23
      state_next.waveform_mode_sel      = wdata_i[C2_WFM_HI:C2_WFM_LO]; // RULE_23
      if (wdata_i[C2_RELEASE]) begin
        state_next.emergency_stop_flag = 1'b0; // RULE_01
      end
    end
    if (wr_c3) begin
      state_next.first_irq_suppress = wdata_i[C3_SUPPRESS];
      state_next.stop_behaviour_sel = wdata_i[C3_STM_HI:C3_STM_LO]; // RULE_23
      state_next.run_bit            = wdata_i[C3_RUN]; // RULE_13
    end

    // Counter datapath and run sequencing
    unique case (state_reg.st)
      ST_IDLE: begin
        state_next.cnt = VAL_ZERO;
      end
      ST_ARMED: begin
        if (trig_ok) begin
          state_next.st           = ST_RUN;
          state_next.cnt          = VAL_ZERO;
          state_next.first_period = 1'b0;
        end
      end
      ST_RUN, ST_FINISH: begin
        if (period_end) begin
          state_next.cnt        = VAL_ZERO;
          state_next.half_phase = !state_reg.half_phase;
          state_next.irq        = !(state_reg.first_irq_suppress && state_reg.first_period); // RULE_09
          state_next.first_period = 1'b0;
          if (state_reg.st == ST_FINISH
              || state_reg.stop_behaviour_sel == STM_ONE_SHOT) begin
            state_next.st = ST_IDLE; // RULE_11 RULE_12
          end
        end else begin
          state_next.cnt = state_reg.cnt + VAL_ONE;
        end
        if (trig_start_mode && trig_ok && state_reg.st == ST_RUN) begin
          state_next.cnt        = VAL_ZERO;
          state_next.half_phase = 1'b0;
        end
      end
      default: begin
        state_next.st = ST_IDLE;
      end
    endcase

    if (wr_c3) begin
      if (wdata_i[C3_RUN]) begin
        // Any write with run set restarts from the initial state
        state_next.cnt        = VAL_ZERO;
        state_next.half_phase = 1'b0;
        if (cmd_mode) begin
          state_next.st           = ST_RUN; // RULE_15
          state_next.first_period = 1'b1;
        end else begin
          state_next.st = ST_ARMED;
        end
      end else if (wdata_i[C3_STM_HI:C3_STM_LO] == STM_ONE_SHOT && counting) begin
        state_next.st = ST_FINISH; // RULE_11
      end else begin
        state_next.st  = ST_IDLE; // RULE_10
        state_next.cnt = VAL_ZERO;
      end
    end

    // Pin sampled only after two flops; set wins over release
    if (state_reg.emergency_input_enable && state_reg.emg_sync2) begin // RULE_03
      state_next.emergency_stop_flag = 1'b1; // RULE_22
    end
    if (state_next.emergency_stop_flag) begin
      state_next.st  = ST_IDLE; // RULE_22
      state_next.cnt = VAL_ZERO;
      state_next.irq = 1'b0;
    end

    // Outputs return to initial levels when not counting or stopped
    state_next.out1 = out1_init_i ^ (act1 && !state_next.emergency_stop_flag
                                     && state_next.st != ST_IDLE); // RULE_10 RULE_22
    state_next.out2 = out2_init_i ^ (act2 && !state_next.emergency_stop_flag
                                     && state_next.st != ST_IDLE); // RULE_10 RULE_22

    if (rd_i) begin
      unique case (addr_i)
        CTRL_TWO_ADDR: begin
          state_next.rdata = {1'b0, state_reg.emergency_input_enable, // RULE_02
                              state_reg.out2_trigger_gate, state_reg.out1_trigger_gate,
                              state_reg.count_start_mode_sel, state_reg.waveform_mode_sel};
        end
        CTRL_THREE_ADDR: begin
          state_next.rdata = {FIELD_ZERO, state_reg.emergency_stop_flag, // RULE_17 RULE_07
                              counting, state_reg.first_irq_suppress, // RULE_08
                              state_reg.stop_behaviour_sel, state_reg.run_bit};
        end
        DEAD_ONE_LO:  state_next.rdata = dead_hold[7:0];
        DEAD_ONE_HI:  state_next.rdata = {6'h00, dead_hold[9:8]}; // RULE_18
        WIDTH_ONE_LO: state_next.rdata = width_hold[7:0];
        WIDTH_ONE_HI: state_next.rdata = {6'h00, width_hold[9:8]}; // RULE_18
        default:      state_next.rdata = REG_RESET;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg    <= '0;
      state_reg.st <= ST_IDLE;
    end else if (ce_i) begin
      state_reg <= state_next;
    end
  end

  assign rdata_o            = state_reg.rdata;
  assign pulse_output_one_o = state_reg.out1;
  assign pulse_output_two_o = state_reg.out2;
  assign period_interrupt_o = state_reg.irq;
  assign counting_o         = counting;
endmodule

//--- verif/ppg_timer_run_control_props.sv
`timescale 1ns/1ps
module ppg_timer_run_control_props
  import ppg_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic        ce_i,
  input wire logic [11:0] addr_i,
  input wire logic [7:0]  wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [7:0]  rdata_o,
  input wire logic        trig_gate_mode_i,
  input wire logic        trig_rising_i,
  input wire logic        out1_init_i,
  input wire logic        out2_init_i,
  input wire logic [1:0]  noise_filter_sel_i,
  input wire logic [9:0]  period_cmp_i,
  input wire logic        period_commit_i,
  input wire logic        trigger_pin_i,
  input wire logic        emergency_input_pin_i,
  input wire logic        pulse_output_one_o,
  input wire logic        pulse_output_two_o,
  input wire logic        period_interrupt_o,
  input wire logic        counting_o
);
  logic [1:0]  csm_reg;
  logic        en_reg;
  logic        run_reg;
  logic [10:0] quiet_reg;
  wire         w2 = ce_i && wr_i && addr_i == CTRL_TWO_ADDR;
  wire         w3 = ce_i && wr_i && addr_i == CTRL_THREE_ADDR;
  wire         r3 = ce_i && rd_i && addr_i == CTRL_THREE_ADDR;
  // Shadow of written fields, since the checker sees only ports
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      csm_reg <= FIELD_ZERO;
      en_reg <= 1'b0;
      run_reg <= 1'b0;
      quiet_reg <= 11'h000;
    end else begin
      if (w2) begin
        csm_reg <= wdata_i[3:2];
        en_reg <= wdata_i[6];
      end
      if (w3) begin
        run_reg <= wdata_i[0];
      end
      // Window spans past the first period end but short of the second
      if (w3) begin
        quiet_reg <= (wdata_i[0] && wdata_i[3] && !csm_reg[1]) ? {1'b0, period_cmp_i} + 11'h003 : 11'h000;
      end else if (quiet_reg != 11'h000) begin
        quiet_reg <= quiet_reg - 11'h001;
      end
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  release_rd_a: assert property (ce_i && rd_i && addr_i == CTRL_TWO_ADDR |=> !rdata_o[7])
    else $error("release bit read as one");
  c3_top_a: assert property (r3 |=> rdata_o[7:6] == 2'h0)
    else $error("control three top bits not zero");
  hi_bits_a: assert property (ce_i && rd_i && (addr_i == DEAD_ONE_HI || addr_i == WIDTH_ONE_HI)
    |=> rdata_o[7:2] == 6'h00)
    else $error("setup high byte upper bits not zero");
  run_hold_a: assert property (r3 |=> rdata_o[0] == $past(run_reg))
    else $error("run bit differs from last write");
  cnt_flag_a: assert property (r3 |=> rdata_o[4] == $past(counting_o))
    else $error("counting flag differs from counting");
  cmd_start_a: assert property (w3 && wdata_i[0] && !csm_reg[1] && !emergency_input_pin_i |=> counting_o)
    else $error("command start did not count");
  stop_now_a: assert property (w3 && !wdata_i[0] && wdata_i[2:1] != STM_ONE_SHOT
    |-> ##[1:2] (!counting_o && pulse_output_one_o == out1_init_i && pulse_output_two_o == out2_init_i))
    else $error("immediate stop not seen");
  emg_stop_a: assert property (ce_i && en_reg && emergency_input_pin_i
    |-> ##[3:4] (!counting_o && pulse_output_one_o == out1_init_i))
    else $error("emergency did not stop outputs");
  first_irq_a: assert property (quiet_reg != 11'h000 |-> !period_interrupt_o)
    else $error("first period interrupt not suppressed");
  cover property (w3 && wdata_i[0]);
  cover property (period_interrupt_o);
  cover property (en_reg && emergency_input_pin_i);
  cover property (trig_gate_mode_i && counting_o);
endmodule

bind ppg_timer_run_control ppg_timer_run_control_props u_props (.*);

//--- verif/ppg_far_side.sv
`timescale 1ns/1ps
module ppg_far_side (
  input  wire logic clk_i,
  input  wire logic out_one_i,
  output logic      trig_o,
  output logic      emg_o
);
  int   edges = 0;
  logic last  = 1'b0;
  initial begin
    trig_o = 1'b0;
    emg_o = 1'b0;
  end
  // Output stage: count rising edges of the first pulse output
  always @(posedge clk_i) begin
    if (out_one_i && !last) edges++;
    last <= out_one_i;
  end
  // Trigger pulse of len clock periods, idle low between pulses
  task automatic pulse(input int len);
    @(posedge clk_i);
    trig_o <= 1'b1;
    repeat (len) @(posedge clk_i);
    trig_o <= 1'b0;
    #1;
  endtask
  task automatic emg(input logic lvl);
    @(posedge clk_i);
    emg_o <= lvl;
    #1;
  endtask
endmodule

//--- verif/test_ppg_timer_run_control.sv
`timescale 1ns/1ps
`define CHK(nm, e, a) begin num_checks++; if ((a) !== (e)) begin n_mismatch++; $display("mismatch %s exp %h got %h", nm, e, a); end end
module test_ppg_timer_run_control
  import ppg_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        ce_i = 1'b1;
  logic [11:0] addr_i = 12'h000;
  logic [7:0]  wdata_i = 8'h00;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        trig_gate_mode_i = 1'b0;
  logic        trig_rising_i = 1'b1;
  logic        out1_init_i = 1'b1;
  logic        out2_init_i = 1'b0;
  logic [1:0]  noise_filter_sel_i = 2'h3;
  logic [9:0]  period_cmp_i = 10'h009;
  logic        period_commit_i = 1'b0;
  wire logic   trigger_pin_i;
  wire logic   emergency_input_pin_i;
  logic [7:0]  rdata_o;
  logic        pulse_output_one_o;
  logic        pulse_output_two_o;
  logic        period_interrupt_o;
  logic        counting_o;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          cycles = 0;

  ppg_timer_run_control u_dut (.*);
  ppg_far_side u_far (.clk_i(clk_i), .out_one_i(pulse_output_one_o), .trig_o(trigger_pin_i),
    .emg_o(emergency_input_pin_i));

  always #12.5 clk_i = ~clk_i;

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Whole run is well under a thousand cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [7:0] e, input string nm);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    `CHK(nm, e, rdata_o)
  endtask
  // Bounded wait; n reaches mx when the level never shows
  task automatic wt(input bit irq, input logic lvl, input int mx, output int n);
    n = 0;
    while (((irq ? period_interrupt_o : counting_o) !== lvl) && n < mx) begin
      @(negedge clk_i);
      n++;
    end
  endtask
  task automatic setv();
    wr(DEAD_ONE_LO, 8'h02);
    wr(DEAD_ONE_HI, 8'h00);
    wr(WIDTH_ONE_LO, 8'h03);
    wr(WIDTH_ONE_HI, 8'h00);
    @(posedge clk_i);
    period_commit_i <= 1'b1;
    @(posedge clk_i);
    period_commit_i <= 1'b0;
  endtask

  task automatic t_regs();
    for (logic [11:0] a = 12'he98; a <= 12'he9e; a++) rdc(a, REG_RESET, "reset");
    wr(CTRL_TWO_ADDR, 8'hff);
    rdc(CTRL_TWO_ADDR, 8'h7f, "c2");
    wr(CTRL_THREE_ADDR, 8'hfe);
    rdc(CTRL_THREE_ADDR, 8'h0e, "c3");
    wr(DEAD_ONE_LO, 8'ha5);
    wr(DEAD_ONE_HI, 8'hff);
    wr(WIDTH_ONE_LO, 8'h5a);
    wr(WIDTH_ONE_HI, 8'hfe);
    rdc(DEAD_ONE_LO, 8'ha5, "dlo");
    rdc(DEAD_ONE_HI, 8'h03, "dhi");
    rdc(WIDTH_ONE_LO, 8'h5a, "wlo");
    rdc(WIDTH_ONE_HI, 8'h02, "whi");
    wr(CTRL_TWO_ADDR, 8'h00);
    wr(CTRL_THREE_ADDR, 8'h00);
    $display("regs done");
  endtask

  task automatic t_start();
    int n;
    int e0;
    logic [7:0] m [3] = '{8'h00, 8'h06, 8'h07};
    foreach (m[i]) begin
      wr(CTRL_TWO_ADDR, m[i]);
      setv();
      e0 = u_far.edges;
      wr(CTRL_THREE_ADDR, 8'h01);
      `CHK("start", 1'b1, counting_o)
      wt(1, 1'b1, 14, n);
      `CHK("irq", 1'b1, (n <= 12))
      // Half duty only rises again after its second period
      repeat (14) @(negedge clk_i);
      `CHK("wave", 1'b1, (u_far.edges != e0))
      rdc(CTRL_THREE_ADDR, 8'h11, "run");
      wr(CTRL_THREE_ADDR, (i == 1) ? 8'h02 : 8'h00);
      repeat (2) @(negedge clk_i);
      `CHK("stop", 3'b010, {counting_o, pulse_output_one_o, pulse_output_two_o})
    end
    $display("start done");
  endtask

  task automatic t_supp();
    int n;
    wr(CTRL_THREE_ADDR, 8'h09);
    wt(1, 1'b1, 40, n);
    `CHK("suppress", 1'b1, (n >= 15 && n <= 25))
    wr(CTRL_THREE_ADDR, 8'h01);
    repeat (6) @(posedge clk_i);
    wr(CTRL_THREE_ADDR, 8'h01);
    wt(1, 1'b1, 14, n);
    `CHK("restart", 1'b1, (n >= 8 && n <= 12))
    wr(CTRL_THREE_ADDR, 8'h05);
    wt(0, 1'b0, 30, n);
    `CHK("one shot", 1'b1, (n > 8 && n < 30))
    rdc(CTRL_THREE_ADDR, 8'h05, "run kept");
    wr(CTRL_THREE_ADDR, 8'h01);
    repeat (3) @(posedge clk_i);
    wr(CTRL_THREE_ADDR, 8'h04);
    `CHK("finish", 1'b1, counting_o)
    wt(0, 1'b0, 30, n);
    `CHK("finish end", 1'b1, (n >= 2 && n <= 12))
    $display("suppress done");
  endtask

  task automatic t_trig();
    int n;
    int w [4] = '{16, 8, 4, 1};
    wr(CTRL_TWO_ADDR, 8'h08);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      noise_filter_sel_i <= 2'(i);
      // Last width starts on the falling edge
      trig_rising_i <= (i != 3);
      wr(CTRL_THREE_ADDR, 8'h01);
      `CHK("armed", 1'b0, counting_o)
      if (i < 3) begin
        u_far.pulse(w[i] - 2);
        wt(0, 1'b1, 40, n);
        `CHK("short", 40, n)
      end
      u_far.pulse(w[i] + 2);
      wt(0, 1'b1, 40, n);
      `CHK("long", 1'b1, counting_o)
      wr(CTRL_THREE_ADDR, 8'h00);
    end
    $display("trigger done");
  endtask

  // Second trigger lands while out1 is active in the half duty period
  task automatic t_gate();
    int n;
    wr(CTRL_TWO_ADDR, 8'h1b);
    for (int g = 1; g >= 0; g--) begin
      @(posedge clk_i);
      trig_rising_i <= 1'b1;
      trig_gate_mode_i <= 1'(g);
      wr(CTRL_THREE_ADDR, 8'h01);
      u_far.pulse(3);
      wt(1, 1'b1, 20, n);
      u_far.pulse(3);
      wt(1, 1'b1, 20, n);
      `CHK("gate", (g == 1), (n < 10))
      wr(CTRL_THREE_ADDR, 8'h00);
    end
    trig_gate_mode_i <= 1'b0;
    $display("gate done");
  endtask

  task automatic t_emg();
    wr(CTRL_TWO_ADDR, 8'h00);
    wr(CTRL_THREE_ADDR, 8'h01);
    u_far.emg(1'b1);
    repeat (8) @(negedge clk_i);
    `CHK("pin off", 1'b1, counting_o)
    u_far.emg(1'b0);
    wr(CTRL_THREE_ADDR, 8'h00);
    wr(CTRL_TWO_ADDR, 8'h40);
    wr(CTRL_THREE_ADDR, 8'h01);
    u_far.emg(1'b1);
    repeat (6) @(negedge clk_i);
    `CHK("emg", 3'b010, {counting_o, pulse_output_one_o, pulse_output_two_o})
    rdc(CTRL_THREE_ADDR, 8'h21, "flag");
    wr(CTRL_THREE_ADDR, 8'h00);
    wr(CTRL_TWO_ADDR, 8'hc0);
    rdc(CTRL_THREE_ADDR, 8'h20, "set wins");
    u_far.emg(1'b0);
    wr(CTRL_TWO_ADDR, 8'h40);
    rdc(CTRL_THREE_ADDR, 8'h20, "zero write");
    wr(CTRL_TWO_ADDR, 8'hc0);
    rdc(CTRL_THREE_ADDR, 8'h00, "released");
    rdc(CTRL_TWO_ADDR, 8'h40, "release rd");
    wr(CTRL_TWO_ADDR, 8'h00);
    $display("emergency done");
  endtask

  initial begin
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_regs();
    t_start();
    t_supp();
    t_trig();
    t_gate();
    t_emg();
    summarize();
  end
endmodule
